// ===== logic/spw_pkg.sv
// Purpose: shared constants, types and register map of the self-polling wake-up scheduler
// Assumes: apb data 32 bits, one aligned word per register
// Notes: timing fields count reference-timer ticks
package spw_pkg;

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] SPW_ADDR_CTRL = 8'h00;
   localparam logic [7:0] SPW_ADDR_REF = 8'h04;
   localparam logic [7:0] SPW_ADDR_ON_A = 8'h08;   // on times a..d at 08,0c,10,14
   localparam logic [7:0] SPW_ADDR_OFF = 8'h18;
   localparam logic [7:0] SPW_ADDR_CHCFG = 8'h1c;
   localparam logic [7:0] SPW_ADDR_THRESH = 8'h20;
   localparam logic [7:0] SPW_ADDR_LOT = 8'h24;
   localparam logic [7:0] SPW_ADDR_SYNC_TO = 8'h28;
   localparam logic [7:0] SPW_ADDR_CMD = 8'h2c;
   localparam logic [7:0] SPW_ADDR_STATUS = 8'h30;
   localparam logic [7:0] SPW_ADDR_PEAK = 8'h34;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SPW_CTRL_MODE_LSB = 0;         // polling_control mode, 2 bits
   localparam int SPW_CTRL_MULTI = 2;
   localparam int SPW_CTRL_ENABLE = 3;
   localparam int SPW_CTRL_DATA_SEL = 4;
   localparam int SPW_CTRL_SIGREC_SEL = 5;
   localparam int SPW_CTRL_COMB_EN = 6;          // combined_level_enable
   localparam int SPW_CTRL_RXMODE_LSB = 8;       // 3 bits
   localparam int SPW_TH_WAKE_LSB = 0;
   localparam int SPW_TH_BLK_HI_LSB = 8;
   localparam int SPW_TH_BLK_LO_LSB = 16;
   localparam int SPW_CMD_RESTART = 0;
   localparam logic [31:0] SPW_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] SPW_TIME_RESET = 32'h0000_0001;

   // ----------------------------------------------------------------
   // modes and timing
   // ----------------------------------------------------------------
   localparam logic [1:0] SPW_MODE_COO = 2'h0;    // constant_on_off_mode
   localparam logic [1:0] SPW_MODE_FFB = 2'h1;    // fast_fallback_mode
   localparam logic [1:0] SPW_MODE_MM = 2'h2;     // mixed_polling_mode
   localparam logic [1:0] SPW_MODE_PERMANENT_SEARCH_MODE = 2'h3;   // permanent_search_mode
   localparam logic [2:0] SPW_RX_POF = 3'h0;      // packet_fifo_rx_mode
   localparam logic [2:0] SPW_RX_PACKET_TRANSPARENT_PAYLOAD_MODE = 3'h1;     // packet_transparent_payload_mode
   localparam logic [2:0] SPW_RX_TRANSPARENT_CHIP_STROBE_MODE = 3'h2;    // transparent_chip_strobe_mode
   localparam int SPW_SYS_DIV = 64;
   localparam int SPW_NUM_CFG = 4;

   typedef enum logic [5:0] {
      SPW_IDLE = 6'b000001,
      SPW_LEVEL = 6'b000010,
      SPW_DATA = 6'b000100,
      SPW_HOLD = 6'b001000,
      SPW_OFF = 6'b010000,
      SPW_RUN = 6'b100000
   } spw_state_t;

   // status from the receiver datapath
   typedef struct packed {
      logic [7:0] rssi;
      logic [7:0] sigrec;
      logic bit_sync;
      logic data_ok;
      logic data_fail;
   } spw_rx_stat_t;

   // control towards the receiver
   typedef struct packed {
      logic rx_on;
      logic [1:0] cfg_sel;
      logic [1:0] chan_sel;
      logic wu_init;
      logic run_mode;
      logic wakeup;
   } spw_rx_ctl_t;

   typedef struct packed {
      logic last;
      logic [1:0] cfg;
      logic [1:0] chan;
   } spw_slot_t;

endpackage

// ===== logic/spw_scheduler.sv
// Purpose: self-polling wake-up scheduler with apb register file
// Assumes: receiver status arrives synchronous to pclk
// Notes: one sequencer, timers from pclk/64 scaled by the reference timer
`timescale 1ns/1ps
module spw_scheduler
   import spw_pkg::*;
#(
   parameter int TW = 16          // width of on/off counters
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // receiver side
   input wire spw_rx_stat_t rx_stat,
   output spw_rx_ctl_t rx_ctl
);

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   logic [31:0] ctrl, ref_time, off_time, chcfg, thresh, lot_time, sync_to;
   logic [31:0] on_time [SPW_NUM_CFG];
   logic [7:0] wakeup_rssi_peak;
   logic restart_cmd;
   logic cfg_err;
   spw_state_t state, next_state;
   logic [1:0] cfg, chan;

   wire logic wr_en = psel & penable & pwrite;
   wire logic setup = psel & ~penable;

   function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] nw,
                                                input logic [3:0] stb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (stb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic addr_mapped(input logic [7:0] a);
      return (a <= SPW_ADDR_PEAK) && (a[1:0] == 2'h0);
   endfunction

   // software writes, full aligned words with byte strobes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= SPW_CTRL_RESET;
         ref_time <= SPW_TIME_RESET;
         off_time <= SPW_TIME_RESET;
         chcfg <= SPW_CTRL_RESET;
         thresh <= SPW_CTRL_RESET;
         lot_time <= SPW_TIME_RESET;
         sync_to <= SPW_TIME_RESET;
         for (int i = 0; i < SPW_NUM_CFG; i++) begin
            on_time[i] <= SPW_TIME_RESET;
         end
      end else if (wr_en) begin
         unique case (paddr)
            SPW_ADDR_CTRL: ctrl <= strobe_merge(ctrl, pwdata, pstrb);
            SPW_ADDR_REF: ref_time <= strobe_merge(ref_time, pwdata, pstrb);
            SPW_ADDR_OFF: off_time <= strobe_merge(off_time, pwdata, pstrb);
            SPW_ADDR_CHCFG: chcfg <= strobe_merge(chcfg, pwdata, pstrb);
            SPW_ADDR_THRESH: thresh <= strobe_merge(thresh, pwdata, pstrb);
            SPW_ADDR_LOT: lot_time <= strobe_merge(lot_time, pwdata, pstrb);
            SPW_ADDR_SYNC_TO: sync_to <= strobe_merge(sync_to, pwdata, pstrb);
            default: begin
               for (int i = 0; i < SPW_NUM_CFG; i++) begin
                  if (paddr == SPW_ADDR_ON_A + 8'(4 * i)) begin
                     on_time[i] <= strobe_merge(on_time[i], pwdata, pstrb);
                  end
               end
            end
         endcase
      end
   end

   // command register is write-only, restart is a one-cycle pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         restart_cmd <= 1'b0;
      end else begin
         restart_cmd <= wr_en && (paddr == SPW_ADDR_CMD) && pstrb[0] && pwdata[SPW_CMD_RESTART];
      end
   end

   // read data captured in the setup cycle so the access phase needs no wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= ~addr_mapped(paddr);
         prdata <= 32'h0000_0000;
         if (!pwrite) begin
            unique case (paddr)
               SPW_ADDR_CTRL: prdata <= ctrl;
               SPW_ADDR_REF: prdata <= ref_time;
               SPW_ADDR_OFF: prdata <= off_time;
               SPW_ADDR_CHCFG: prdata <= chcfg;
               SPW_ADDR_THRESH: prdata <= thresh;
               SPW_ADDR_LOT: prdata <= lot_time;
               SPW_ADDR_SYNC_TO: prdata <= sync_to;
               SPW_ADDR_STATUS: prdata <= {20'h00000, cfg_err, chan, cfg, 1'b0, state};
               SPW_ADDR_PEAK: prdata <= {24'h000000, wakeup_rssi_peak};
               default: begin
                  for (int i = 0; i < SPW_NUM_CFG; i++) begin
                     if (paddr == SPW_ADDR_ON_A + 8'(4 * i)) begin
                        prdata <= on_time[i];
                     end
                  end
               end
            endcase
         end
      end
   end

   assign pready = 1'b1;

   // ----------------------------------------------------------------
   // configuration decode
   // ----------------------------------------------------------------
   wire logic [1:0] mode = ctrl[SPW_CTRL_MODE_LSB +: 2];
   wire logic multi_cfg = ctrl[SPW_CTRL_MULTI];
   wire logic enable = ctrl[SPW_CTRL_ENABLE];
   wire logic data_sel = ctrl[SPW_CTRL_DATA_SEL];
   wire logic sigrec_sel = ctrl[SPW_CTRL_SIGREC_SEL];
   wire logic comb_en = ctrl[SPW_CTRL_COMB_EN];
   wire logic [2:0] rx_mode = ctrl[SPW_CTRL_RXMODE_LSB +: 3];
   wire logic [7:0] wake_th = thresh[SPW_TH_WAKE_LSB +: 8];
   wire logic [7:0] blk_hi = thresh[SPW_TH_BLK_HI_LSB +: 8];
   wire logic [7:0] blk_lo = thresh[SPW_TH_BLK_LO_LSB +: 8];

   // fast fallback based modes only accept three receive modes
   assign cfg_err = (mode != SPW_MODE_COO) && (rx_mode != SPW_RX_POF) &&
                    (rx_mode != SPW_RX_PACKET_TRANSPARENT_PAYLOAD_MODE) && (rx_mode != SPW_RX_TRANSPARENT_CHIP_STROBE_MODE);

   // ultrafast fallback qualification
   wire logic ultrafast_fallback_mode = data_sel && comb_en &&
                          (mode == SPW_MODE_FFB || mode == SPW_MODE_PERMANENT_SEARCH_MODE);

   // a slot follows constant on-off rules in coo mode and for set a in mixed mode
   function automatic logic coo_slot(input logic [1:0] m, input logic [1:0] c);
      return (m == SPW_MODE_COO) || (m == SPW_MODE_MM && c == 2'h0);
   endfunction

   // next configuration / channel; channel count per set is chcfg[2c+1:2c] + 1
   function automatic spw_slot_t next_slot(input logic [1:0] c, input logic [1:0] ch);
      spw_slot_t s;
      s = '{last: 1'b0, cfg: c, chan: ch};
      if (ch < chcfg[2*c +: 2]) begin
         s.chan = ch + 2'h1;
      end else if (multi_cfg && c != 2'(SPW_NUM_CFG - 1)) begin
         s.cfg = c + 2'h1;
         s.chan = 2'h0;
      end else begin
         s.last = 1'b1;
         s.cfg = 2'h0;
         s.chan = 2'h0;
      end
      return s;
   endfunction

   // ----------------------------------------------------------------
   // timebase: pclk/64 then reference timer
   // ----------------------------------------------------------------
   logic [5:0] div64;
   logic [15:0] ref_cnt;
   logic tick;

   // reference timer trades resolution against the longest reachable on/off time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div64 <= 6'h00;
         ref_cnt <= 16'h0000;
         tick <= 1'b0;
      end else begin
         div64 <= div64 + 6'h01;
         tick <= 1'b0;
         if (div64 == 6'(SPW_SYS_DIV - 1)) begin
            if (ref_cnt >= ref_time[15:0] || ref_cnt == 16'hffff) begin
               ref_cnt <= 16'h0000;
               tick <= 1'b1;
            end else begin
               ref_cnt <= ref_cnt + 16'h0001;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   logic [TW-1:0] tm_cnt;
   logic [7:0] lot_cnt, sync_cnt, peak;
   logic synced;
   logic start_slot, load_on, load_off, init_wu, wake, win_restart;
   logic [1:0] tgt_cfg, tgt_chan;
   spw_slot_t adv;

   wire logic cur_coo = coo_slot(mode, cfg);
   wire logic tm_done = tick && (tm_cnt <= TW'(1));
   wire logic lot_done = tick && (lot_cnt <= 8'h01);
   wire logic sync_done = tick && (sync_cnt <= 8'h01);
   wire logic [7:0] src = sigrec_sel ? rx_stat.sigrec : rx_stat.rssi;
   wire logic win_ok = (peak > wake_th) && (peak > blk_hi);
   wire logic final_ok = (peak > wake_th) && ((peak < blk_lo) || (peak > blk_hi));
   wire logic comb_ok = sigrec_sel ? (peak > blk_hi) : final_ok;
   wire logic level_first = !data_sel || (comb_en && (cur_coo || ultrafast_fallback_mode));

   // next state and sequencing actions
   always_comb begin
      next_state = state;
      start_slot = 1'b0;
      load_on = 1'b0;
      load_off = 1'b0;
      init_wu = 1'b0;
      wake = 1'b0;
      win_restart = 1'b0;
      adv = next_slot(cfg, chan);
      tgt_cfg = adv.cfg;
      tgt_chan = adv.chan;
      unique case (state)
         SPW_IDLE: begin
            if (enable && !cfg_err) begin
               tgt_cfg = 2'h0;
               tgt_chan = 2'h0;
               start_slot = 1'b1;
               load_on = 1'b1;
            end
         end
         SPW_LEVEL, SPW_DATA: begin
            if (tm_done) begin
               if (state == SPW_LEVEL && !data_sel && cur_coo && final_ok) begin
                  wake = 1'b1;
               end else if (!cur_coo || adv.last) begin
                  load_off = mode != SPW_MODE_PERMANENT_SEARCH_MODE || !cur_coo || adv.last;
               end else begin
                  start_slot = 1'b1;
                  load_on = 1'b1;
               end
            end else if (!cur_coo && data_sel && sync_done && !synced) begin
               start_slot = 1'b1;
            end else if (state == SPW_LEVEL && lot_done) begin
               if (!data_sel) begin
                  if (cur_coo ? win_ok : final_ok) begin
                     wake = 1'b1;
                  end else if (cur_coo) begin
                     win_restart = 1'b1;
                  end else begin
                     start_slot = 1'b1;
                  end
               end else if (comb_ok) begin
                  next_state = SPW_DATA;
               end else if (cur_coo) begin
                  init_wu = 1'b1;
               end else begin
                  start_slot = 1'b1;
               end
            end else if (state == SPW_DATA) begin
               if (rx_stat.data_ok) begin
                  wake = 1'b1;
               end else if (rx_stat.data_fail) begin
                  init_wu = 1'b1;
                  if (cur_coo) begin
                     next_state = level_first ? SPW_LEVEL : SPW_DATA;
                  end else begin
                     start_slot = 1'b1;
                  end
               end else if (synced && !rx_stat.bit_sync) begin
                  init_wu = 1'b1;
                  if (cur_coo) begin
                     next_state = level_first ? SPW_LEVEL : SPW_DATA;
                  end else begin
                     start_slot = 1'b1;
                  end
               end
            end
            // an abandoned fast fallback slot either moves on, wraps or idles out the on time
            if (start_slot && !cur_coo && !tm_done) begin
               if (adv.last && mode != SPW_MODE_PERMANENT_SEARCH_MODE) begin
                  start_slot = 1'b0;
                  next_state = SPW_HOLD;
               end else begin
                  load_on = 1'b0;
               end
            end
            // coo set a handing over to the mixed mode group loads that group's on time
            if (start_slot && cur_coo && !coo_slot(mode, adv.cfg)) begin
               load_on = 1'b1;
            end
            if (load_off) begin
               next_state = SPW_OFF;
            end
            if (wake) begin
               next_state = SPW_RUN;
               start_slot = 1'b0;
            end
         end
         SPW_HOLD: begin
            if (tm_done) begin
               load_off = 1'b1;
               next_state = SPW_OFF;
            end
         end
         SPW_OFF: begin
            if (tm_done) begin
               tgt_cfg = 2'h0;
               tgt_chan = 2'h0;
               start_slot = 1'b1;
               load_on = 1'b1;
            end
         end
         SPW_RUN: begin
            if (restart_cmd) begin
               next_state = SPW_IDLE;
            end
         end
      endcase
      if (start_slot) begin
         next_state = (!data_sel || (comb_en && (coo_slot(mode, tgt_cfg) || ultrafast_fallback_mode))) ?
                      SPW_LEVEL : SPW_DATA;
      end
      if (!enable) begin
         next_state = SPW_IDLE;
      end
   end

   // state, slot pointer and on/off timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= SPW_IDLE;
         cfg <= 2'h0;
         chan <= 2'h0;
         tm_cnt <= '0;
      end else begin
         state <= next_state;
         if (start_slot) begin
            cfg <= tgt_cfg;
            chan <= tgt_chan;
         end
         if (load_off) begin
            tm_cnt <= off_time[TW-1:0];
         end else if (load_on) begin
            tm_cnt <= on_time[tgt_cfg][TW-1:0];
         end else if (tick && tm_cnt != '0) begin
            tm_cnt <= tm_cnt - TW'(1);
         end
      end
   end

   // observation window and sync search timers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lot_cnt <= 8'h00;
         sync_cnt <= 8'h00;
         synced <= 1'b0;
      end else begin
         if (start_slot || init_wu || win_restart) begin
            lot_cnt <= lot_time[7:0];
         end else if (tick && lot_cnt != 8'h00) begin
            lot_cnt <= lot_cnt - 8'h01;
         end
         // sync search starts with the slot, in parallel with the level window
         if (start_slot || init_wu) begin
            sync_cnt <= sync_to[7:0];
            synced <= 1'b0;
         end else begin
            if (tick && sync_cnt != 8'h00) begin
               sync_cnt <= sync_cnt - 8'h01;
            end
            if (rx_stat.bit_sync) begin
               synced <= 1'b1;
            end
         end
      end
   end

   // the receiver shows a real level one cycle after it is switched on; until then its
   // status is junk and must stay out of the peak
   logic rx_live;

   // peak tracking survives window changes, cleared on slot start or unit init
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peak <= 8'h00;
         rx_live <= 1'b0;
      end else begin
         rx_live <= rx_ctl.rx_on;
         if (start_slot || init_wu) begin
            peak <= 8'h00;
         end else if (rx_live && src > peak) begin
            peak <= src;
         end
      end
   end

   // frozen peak and outputs to the receiver
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wakeup_rssi_peak <= 8'h00;
         rx_ctl <= '0;
      end else begin
         if (wake) begin
            wakeup_rssi_peak <= peak;
         end
         rx_ctl.rx_on <= next_state inside {SPW_LEVEL, SPW_DATA, SPW_RUN};
         rx_ctl.cfg_sel <= start_slot ? tgt_cfg : cfg;
         rx_ctl.chan_sel <= start_slot ? tgt_chan : chan;
         rx_ctl.wu_init <= init_wu || start_slot;
         rx_ctl.run_mode <= next_state == SPW_RUN;
         rx_ctl.wakeup <= wake;
      end
   end

endmodule // spw_scheduler

// ===== test/spw_checker.sv
// Purpose: port checks on the scheduler
// Assumes: zero-wait apb
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module spw_checker
   import spw_pkg::*;
(
   // apb and clock
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // receiver control
   input wire spw_rx_ctl_t rx_ctl
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wake;
      rx_ctl.wakeup ##1 !rx_ctl.wakeup;
   endsequence
   chk_ready_high: assert property (pready) else $error("pready low");
   chk_bad_addr: assert property (psel && !penable && paddr > 8'h34 |=> pslverr) else $error("no slave error");
   chk_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error read not zero");
   chk_wake_pulse: assert property (rx_ctl.wakeup |-> s_wake) else $error("wakeup not a pulse");
   chk_wake_run: assert property (rx_ctl.wakeup |-> rx_ctl.run_mode) else $error("wake without run");
   chk_run_cause: assert property ($rose(rx_ctl.run_mode) |-> rx_ctl.wakeup) else $error("run without wake");
   // two idle bus cycles rule out a pending restart write
   chk_run_hold: assert property ((rx_ctl.run_mode && !psel)[*2] |=> rx_ctl.run_mode) else $error("run dropped");
   chk_run_rx: assert property (rx_ctl.run_mode |-> rx_ctl.rx_on) else $error("run with rx off");
   chk_slot_init: assert property ($rose(rx_ctl.rx_on) |-> ##[0:1] rx_ctl.wu_init) else $error("no unit init");
endmodule // spw_checker
bind spw_scheduler spw_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
   .pslverr, .rx_ctl);

// ===== test/spw_rx_model.sv
// Purpose: receiver datapath stand-in
// Assumes: level path only, no bit sync
// Notes: level is set by the bench
`timescale 1ns/1ps
module spw_rx_model
   import spw_pkg::*;
(
   // inputs
   input wire logic pclk,
   input wire logic presetn,
   input wire spw_rx_ctl_t rx_ctl,
   input wire logic [7:0] level,
   // status out
   output spw_rx_stat_t rx_stat
);
   // ----------------------------------------
   // status
   // ----------------------------------------
   // a switched-off receiver shows toggling junk, never a held level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_stat <= '0;
      end else begin
         rx_stat.rssi <= rx_ctl.rx_on ? level : ~rx_stat.rssi;
         rx_stat.sigrec <= rx_ctl.rx_on ? level : ~rx_stat.sigrec;
      end
   end
endmodule // spw_rx_model

// ===== test/spw_scheduler_bench.sv
// Purpose: directed apb tests of the scheduler
// Assumes: ref 0 gives one tick per 64 clocks
// Notes: level path, constant on-off and fast fallback modes
`timescale 1ns/1ps
module spw_scheduler_bench;
   import spw_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, level;
   logic [31:0] pwdata, prdata, q;
   spw_rx_stat_t rx_stat;
   spw_rx_ctl_t rx_ctl;
   int bad_count = 0;
   int compares = 0;
   int n, off;
   spw_scheduler DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata,
      .pready, .pslverr, .rx_stat, .rx_ctl);
   spw_rx_model u_rx (.pclk, .presetn, .rx_ctl, .level, .rx_stat);
   // ----------------------------------------
   // clock, tasks, watchdog
   // ----------------------------------------
   initial begin
      pclk = 0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // counts cycles to a wakeup and cycles with the receiver off
   task automatic wake_wait(input int lim);
      n = 0;
      off = 0;
      while (rx_ctl.wakeup !== 1'b1 && n < lim) begin
         @(posedge pclk);
         #1;
         n++;
         off += int'(rx_ctl.rx_on !== 1'b1);
      end
   endtask
   task close_out;
      $display("mismatches %0d, compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (25000) @(posedge pclk);
      bad_count++;
      close_out;
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, level} <= '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, SPW_ADDR_CTRL, 32'h0);
      cmp(q, SPW_CTRL_RESET);
      apb(1'b0, SPW_ADDR_OFF, 32'h0);
      cmp(q, SPW_TIME_RESET);
      apb(1'b0, 8'h38, 32'h0);
      cmp({q[31:1], err}, 32'h1);
      apb(1'b1, SPW_ADDR_REF, 32'h0);
      apb(1'b1, SPW_ADDR_ON_A, 32'h4);
      apb(1'b1, SPW_ADDR_OFF, 32'h2);
      apb(1'b1, SPW_ADDR_LOT, 32'h1);
      apb(1'b1, SPW_ADDR_THRESH, 32'h0040_8010);
      level <= 8'h90;
      apb(1'b1, SPW_ADDR_CTRL, 32'h8);
      wake_wait(2000);
      cmp(32'(n < 170), 1);
      cmp(32'({rx_ctl.cfg_sel, rx_ctl.chan_sel}), 0);
      // a quiet bus in run mode must leave run mode standing
      repeat (3) @(posedge pclk);
      apb(1'b0, SPW_ADDR_PEAK, 32'h0);
      cmp(q, 32'h90);
      cmp(32'(rx_ctl.run_mode), 1);
      // below the lower blocking level, then the level drops: only a peak kept across windows wakes at on end
      level <= 8'h30;
      apb(1'b1, SPW_ADDR_CMD, 32'h1);
      repeat (80) @(posedge pclk);
      level <= 8'h00;
      wake_wait(2000);
      cmp(32'(n > 100 && n < 220), 1);
      apb(1'b0, SPW_ADDR_PEAK, 32'h0);
      cmp(q, 32'h30);
      // inside the blocking window: no wake, off time of two ticks every master period
      level <= 8'h60;
      apb(1'b1, SPW_ADDR_CMD, 32'h1);
      wake_wait(1500);
      cmp(32'(n), 1500);
      cmp(32'(off > 400 && off < 600), 1);
      // fast fallback with an unsupported receive mode must not start
      apb(1'b1, SPW_ADDR_CTRL, 32'h0);
      apb(1'b1, SPW_ADDR_CTRL, 32'h309);
      apb(1'b0, SPW_ADDR_STATUS, 32'h0);
      cmp(q, 32'h801);
      // fast fallback level miss: receiver drops out after one window, timer runs on
      apb(1'b1, SPW_ADDR_CTRL, 32'h9);
      wake_wait(1500);
      cmp(32'(off > 1200), 1);
      close_out;
   end
endmodule // spw_scheduler_bench
